/* logic/txsw_regs.vh */
// constants for the transmit status write-back block
// assumes a 10 MHz system clock and word-indexed register addresses
`ifndef TXSW_REGS_VH
`define TXSW_REGS_VH
`define TXSW_OWN 31
`define TXSW_ES 15
`define TXSW_TO 14
`define TXSW_LO 11
`define TXSW_NC 10
`define TXSW_LC 9
`define TXSW_EC 8
`define TXSW_HF 7
`define TXSW_CC_HI 6
`define TXSW_CC_LO 3
`define TXSW_LF 2
`define TXSW_UF 1
`define TXSW_DE 0
`define TXSW_A_MODE 4'h0
`define TXSW_A_STAT 4'h1
`define TXSW_A_MASK 4'h2
`define TXSW_A_LAST 4'h3
`define TXSW_A_COUNT 4'h4
`define TXSW_HIST_BIT 3
`define TXSW_LB_HI 11
`define TXSW_LB_LO 10
`define TXSW_LB_INTERNAL 2'h1
`define TXSW_SYM 23
`define TXSW_SPD10 24
`define TXSW_RESUME 0
`define TXSW_MODE_MASK 32'h01800C00
`define TXSW_I_TXINT 0
`define TXSW_I_JAB 3
`define TXSW_I_UNF 5
`define TXSW_IRQ_MASK 32'h00000029
`define TXSW_WINDOW_BYTES 11'h040
`define TXSW_MAX_COLL 4'hF
`define TXSW_CLK_MHZ 10
`define TXSW_JAB_US 2600
`define TXSW_JAB_CYC (`TXSW_JAB_US * `TXSW_CLK_MHZ)
`define TXSW_HB_NS 4000
`define TXSW_HB_CYC ((`TXSW_HB_NS * `TXSW_CLK_MHZ) / 1000)
`define TXSW_HIST_DEPTH 8
`define TXSW_HIST_AW 3
`endif

/* logic/txsw_mem.v */
// small history memory of written-back status words
// assumes one clock; read data come from a register one cycle after the address
`timescale 1ns/1ps
`default_nettype none
`include "txsw_regs.vh"
module txsw_mem (
    input wire ref_clk,
    input wire ce,
    input wire wr_en,
    input wire [`TXSW_HIST_AW-1:0] wr_addr,
    input wire [31:0] wr_data,
    input wire [`TXSW_HIST_AW-1:0] rd_addr,
    output reg [31:0] rd_data
);
    reg [31:0] mem [0:`TXSW_HIST_DEPTH-1];

    always @(posedge ref_clk) begin
        if (ce) begin
            if (wr_en) begin
                mem[wr_addr] <= wr_data;
            end
            rd_data <= mem[rd_addr];
        end
    end
endmodule
`default_nettype wire

/* logic/txsw_writeback.v */
// transmit status word builder and descriptor write-back, with register slave
// assumes tx engine on ref_clk; carrier and collision pins are asynchronous
//
// The Avalon-MM interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "txsw_regs.vh"
module txsw_writeback #(
    parameter JAB_CYCLES = `TXSW_JAB_CYC
) (
    input wire ref_clk,
    input wire rst_n,
    input wire ce,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    output reg irq,
    input wire crs_pin,
    input wire col_pin,
    input wire frame_ready,
    input wire desc_own,
    input wire tx_busy,
    input wire [10:0] tx_bytes,
    input wire tx_fifo_empty,
    input wire tx_sent,
    input wire link_fail_in,
    output reg tx_go,
    output reg tx_abort,
    output reg tx_stopped,
    output reg tx_suspended,
    output reg wb_valid,
    output reg [31:0] wb_data,
    input wire wb_ready
);
    localparam [5:0] S_IDLE = 6'h01;
    localparam [5:0] S_WAIT = 6'h02;
    localparam [5:0] S_SEND = 6'h04;
    localparam [5:0] S_HB = 6'h08;
    localparam [5:0] S_WB = 6'h10;
    localparam [5:0] S_HALT = 6'h20;

    function has_bit;
        input [31:0] word;
        input [4:0] pos;
        begin
            has_bit = word[pos];
        end
    endfunction

    reg rst_m, rst_s;
    wire rst_sync_n = rst_s;
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_m <= 1'b0;
            rst_s <= 1'b0;
        end else begin
            rst_m <= 1'b1;
            rst_s <= rst_m;
        end
    end

    // three-stage pin sync; a change counts once stages two and three agree
    reg [2:0] crs_q, col_q;
    reg crs_f, col_f;
    always @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            crs_q <= 3'h0;
            col_q <= 3'h0;
            crs_f <= 1'b0;
            col_f <= 1'b0;
        end else if (ce) begin
            crs_q <= {crs_q[1:0], crs_pin};
            col_q <= {col_q[1:0], col_pin};
            if (crs_q[1] == crs_q[2]) begin
                crs_f <= crs_q[2];
            end
            if (col_q[1] == col_q[2]) begin
                col_f <= col_q[2];
            end
        end
    end
    reg col_d, crs_d;
    always @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            col_d <= 1'b0;
            crs_d <= 1'b0;
        end else if (ce) begin
            col_d <= col_f;
            crs_d <= crs_f;
        end
    end
    wire col_rise = col_f & ~col_d;
    wire crs_fall = crs_d & ~crs_f;

    reg [31:0] mode_reg, int_stat, int_mask, last_word, frame_cnt;
    wire loopback = (mode_reg[`TXSW_LB_HI:`TXSW_LB_LO] == `TXSW_LB_INTERNAL);

    reg [5:0] state;
    reg f_to, f_lo, f_nc, f_lc, f_ec, f_hf, f_lf, f_uf, f_de;
    reg [3:0] tally;
    reg crs_seen, retry, halt_stop;
    reg [31:0] jab_cnt;
    reg [15:0] hb_cnt;
    reg ev_txint, ev_jab, ev_unf;

    // assembled status word with own cleared
    reg [31:0] next_word;
    always @* begin
        next_word = 32'h00000000;
        next_word[`TXSW_OWN] = 1'b0;
        next_word[`TXSW_TO] = f_to;
        next_word[`TXSW_LO] = f_lo & ~loopback;
        next_word[`TXSW_NC] = f_nc & ~loopback;
        next_word[`TXSW_LC] = f_lc;
        next_word[`TXSW_EC] = f_ec;
        next_word[`TXSW_HF] = f_hf & ~f_to & ~f_uf;
        next_word[`TXSW_CC_HI:`TXSW_CC_LO] = tally;
        next_word[`TXSW_LF] = f_lf;
        next_word[`TXSW_UF] = f_uf;
        next_word[`TXSW_DE] = f_de;
        next_word[`TXSW_ES] = f_uf | f_ec | f_lc | f_to
            | (f_lo & ~loopback) | (f_nc & ~loopback);
    end

    always @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state <= S_IDLE;
            {f_to, f_lo, f_nc, f_lc, f_ec, f_hf, f_lf, f_uf, f_de} <= 9'h000;
            tally <= 4'h0;
            crs_seen <= 1'b0;
            retry <= 1'b0;
            halt_stop <= 1'b0;
            jab_cnt <= 32'h00000000;
            hb_cnt <= 16'h0000;
            tx_go <= 1'b0;
            tx_abort <= 1'b0;
            tx_stopped <= 1'b0;
            tx_suspended <= 1'b0;
            wb_valid <= 1'b0;
            wb_data <= 32'h00000000;
            last_word <= 32'h00000000;
            frame_cnt <= 32'h00000000;
            ev_txint <= 1'b0;
            ev_jab <= 1'b0;
            ev_unf <= 1'b0;
        end else if (ce) begin
            tx_go <= 1'b0;
            tx_abort <= 1'b0;
            ev_txint <= 1'b0;
            ev_jab <= 1'b0;
            ev_unf <= 1'b0;
            case (state)
                S_IDLE: begin
                    // only a descriptor we own starts a frame
                    if (frame_ready && desc_own) begin
                        {f_to, f_lo, f_nc, f_lc, f_ec} <= 5'h00;
                        {f_hf, f_lf, f_uf, f_de} <= 4'h0;
                        tally <= 4'h0;
                        retry <= 1'b0;
                        state <= S_WAIT;
                    end
                end
                S_WAIT: begin
                    if (crs_f) begin
                        f_de <= 1'b1;
                    end else begin
                        tx_go <= 1'b1;
                        crs_seen <= 1'b0;
                        jab_cnt <= 32'h00000000;
                        f_lf <= link_fail_in & mode_reg[`TXSW_SYM];
                        state <= S_SEND;
                    end
                end
                S_SEND: begin
                    jab_cnt <= jab_cnt + 32'h00000001;
                    if (crs_f) begin
                        crs_seen <= 1'b1;
                    end
                    if (crs_fall && crs_seen) begin
                        f_lo <= 1'b1;
                    end
                    if (jab_cnt >= JAB_CYCLES - 1) begin
                        f_to <= 1'b1;
                        ev_jab <= 1'b1;
                        tx_abort <= 1'b1;
                        halt_stop <= 1'b1;
                        state <= S_WB;
                    end else if (tx_busy && tx_fifo_empty) begin
                        f_uf <= 1'b1;
                        ev_unf <= 1'b1;
                        tx_abort <= 1'b1;
                        halt_stop <= 1'b0;
                        state <= S_WB;
                    end else if (col_rise && tx_bytes >= `TXSW_WINDOW_BYTES) begin
                        f_lc <= 1'b1;
                        tx_abort <= 1'b1;
                        state <= S_WB;
                    end else if (col_rise) begin
                        tx_abort <= 1'b1;
                        retry <= 1'b1;
                        tally <= tally + 4'h1;
                        if (tally == `TXSW_MAX_COLL) begin
                            f_ec <= 1'b1;
                            state <= S_WB;
                        end else begin
                            state <= S_WAIT;
                        end
                    end else if (tx_sent) begin
                        f_nc <= ~crs_seen & ~crs_f;
                        hb_cnt <= 16'h0000;
                        // heartbeat only in 10 Mb mode and first attempt
                        if (mode_reg[`TXSW_SPD10] && !retry) begin
                            state <= S_HB;
                        end else begin
                            f_hf <= 1'b0;
                            state <= S_WB;
                        end
                    end
                end
                S_HB: begin
                    hb_cnt <= hb_cnt + 16'h0001;
                    if (col_rise) begin
                        state <= S_WB;
                    end else if (hb_cnt >= `TXSW_HB_CYC - 1) begin
                        f_hf <= 1'b1;
                        state <= S_WB;
                    end
                end
                S_WB: begin
                    if (!wb_valid) begin
                        wb_valid <= 1'b1;
                        wb_data <= next_word;
                    end else if (wb_ready) begin
                        wb_valid <= 1'b0;
                        last_word <= wb_data;
                        frame_cnt <= frame_cnt + 32'h00000001;
                        if (f_to || f_uf) begin
                            tx_stopped <= halt_stop;
                            tx_suspended <= ~halt_stop;
                            ev_txint <= f_uf;
                            state <= S_HALT;
                        end else begin
                            state <= S_IDLE;
                        end
                    end
                end
                S_HALT: begin
                    if (avs_write && !avs_waitrequest && avs_address == `TXSW_A_MODE
                        && avs_writedata[`TXSW_RESUME]) begin
                        tx_stopped <= 1'b0;
                        tx_suspended <= 1'b0;
                        state <= S_IDLE;
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // history memory of written-back words
    reg [`TXSW_HIST_AW-1:0] hist_wp;
    wire hist_we = ce & (state == S_WB) & wb_valid & wb_ready;
    wire [31:0] hist_rd;
    always @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            hist_wp <= {`TXSW_HIST_AW{1'b0}};
        end else if (hist_we) begin
            hist_wp <= hist_wp + 1'b1;
        end
    end
    txsw_mem u_hist (
        .ref_clk(ref_clk),
        .ce(ce),
        .wr_en(hist_we),
        .wr_addr(hist_wp),
        .wr_data(wb_data),
        .rd_addr(avs_address[`TXSW_HIST_AW-1:0]),
        .rd_data(hist_rd)
    );

    // avalon slave: two-cycle answer so history read data are ready
    reg ack_ph;
    wire take = (avs_read | avs_write) & ~avs_waitrequest;
    wire wr_take = avs_write & ~avs_waitrequest;
    reg [31:0] rd_mux;
    always @* begin
        rd_mux = 32'h00000000;
        if (avs_address[`TXSW_HIST_BIT]) begin
            rd_mux = hist_rd;
        end else begin
            case (avs_address)
                `TXSW_A_MODE: rd_mux = mode_reg;
                `TXSW_A_STAT: rd_mux = int_stat;
                `TXSW_A_MASK: rd_mux = int_mask;
                `TXSW_A_LAST: rd_mux = last_word;
                `TXSW_A_COUNT: rd_mux = frame_cnt;
                default: rd_mux = 32'h00000000;
            endcase
        end
    end

    wire [31:0] ev_vec = ({31'h0, ev_txint | ev_unf} << `TXSW_I_TXINT)
        | ({31'h0, ev_jab} << `TXSW_I_JAB) | ({31'h0, ev_unf} << `TXSW_I_UNF);
    wire [31:0] w1c = (wr_take && avs_address == `TXSW_A_STAT) ?
        avs_writedata : 32'h00000000;

    always @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
            ack_ph <= 1'b0;
            mode_reg <= 32'h00000000;
            int_stat <= 32'h00000000;
            int_mask <= 32'h00000000;
            irq <= 1'b0;
        end else if (ce) begin
            if (take) begin
                avs_waitrequest <= 1'b1;
                ack_ph <= 1'b0;
            end else if ((avs_read || avs_write) && !ack_ph) begin
                ack_ph <= 1'b1;
            end else if ((avs_read || avs_write) && ack_ph) begin
                avs_waitrequest <= 1'b0;
                avs_readdata <= avs_read ? rd_mux : 32'h00000000;
            end
            if (wr_take && avs_address == `TXSW_A_MODE) begin
                mode_reg <= avs_writedata & `TXSW_MODE_MASK;
            end
            if (wr_take && avs_address == `TXSW_A_MASK) begin
                int_mask <= avs_writedata & `TXSW_IRQ_MASK;
            end
            // a new event wins over a simultaneous clear
            int_stat <= ((int_stat & ~w1c) | ev_vec) & `TXSW_IRQ_MASK;
            irq <= has_bit({31'h0, |(int_stat & int_mask)}, 5'h00);
        end
    end
endmodule
`default_nettype wire

/* bench/txsw_asserts.sv */
// port checks for the transmit status write-back block
// assumes ce held high; bound to every txsw_writeback
`timescale 1ns/1ps
`default_nettype none
module txsw_asserts (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic tx_go,
    input wire logic tx_stopped,
    input wire logic tx_suspended,
    input wire logic wb_valid,
    input wire logic [31:0] wb_data,
    input wire logic wb_ready
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_req;
        $rose(avs_read || avs_write);
    endsequence
    sequence s_answer;
        avs_waitrequest ##1 avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    // stop and suspend follow the accepted write-back, not its offer
    sequence s_jab_wb;
        wb_valid && wb_ready && wb_data[14];
    endsequence
    a_bus_answer: assert property (s_req |-> s_answer)
        else $error("bus answer not two cycles after request");
    a_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than a cycle");
    a_es_or: assert property (wb_valid |-> wb_data[15] == |(wb_data & 32'h00004F02))
        else $error("error summary mismatch");
    a_own_back: assert property (wb_valid |-> !wb_data[31])
        else $error("ownership not returned");
    a_hf_void: assert property (wb_valid && (wb_data[14] || wb_data[1]) |-> !wb_data[7])
        else $error("heartbeat fail with jabber or underflow");
    a_wb_hold: assert property (wb_valid && !wb_ready |=> wb_valid && $stable(wb_data))
        else $error("write-back word changed while stalled");
    a_jab_stop: assert property (s_jab_wb |=> tx_stopped)
        else $error("jabber status without stop");
    a_stop_write: assert property ($rose(tx_stopped) |->
        $past(wb_valid) && $past(wb_ready) && $past(wb_data[14]))
        else $error("stop without jabber write-back");
    a_unf_susp: assert property (wb_valid && wb_ready && wb_data[1] |=> tx_suspended)
        else $error("underflow status without suspend");
    a_no_go_halt: assert property (tx_go |-> !tx_stopped && !tx_suspended)
        else $error("attempt started while halted");
endmodule
bind txsw_writeback txsw_asserts txsw_asserts_i (.*);
`default_nettype wire

/* bench/txsw_desc_mem.sv */
// descriptor memory side: takes written-back status words with random stalls
// assumes a word is taken when valid and ready meet at a rising edge
`timescale 1ns/1ps
`default_nettype none
module txsw_desc_mem (
    input wire logic ref_clk,
    input wire logic wb_valid,
    input wire logic [31:0] wb_data,
    output logic wb_ready,
    output logic [31:0] got,
    output logic [7:0] cnt
);
    initial begin
        wb_ready = 1'h0;
        got = 32'h00000000;
        cnt = 8'h00;
    end
    always @(posedge ref_clk) begin
        // host reads the word only once ownership is back
        if (wb_valid && wb_ready && !wb_data[31]) begin
            got <= wb_data;
            cnt <= cnt + 8'h01;
        end
        wb_ready <= ($urandom % 3) != 0;
    end
endmodule
`default_nettype wire

/* bench/testbench.sv */
// self-checking bench for the transmit status write-back block
// assumes the bench plays the tx engine and transceiver pins
`timescale 1ns/1ps
`default_nettype none
`include "txsw_regs.vh"
module testbench;
    localparam logic [31:0] M = 32'hFFFFFFFF;
    logic ref_clk = 1'h0, rst_n = 1'h0, ce = 1'h1;
    logic avs_read, avs_write, avs_waitrequest, irq, crs_pin, col_pin, frame_ready, desc_own;
    logic tx_busy, tx_fifo_empty, tx_sent, link_fail_in, tx_go, tx_abort, tx_stopped;
    logic tx_suspended, wb_valid, wb_ready, lk;
    logic [3:0] avs_address;
    logic [10:0] tx_bytes;
    logic [31:0] avs_writedata, avs_readdata, wb_data, got, q;
    logic [7:0] cnt, c0;
    logic [6:0] f;
    int fail_count = 0, checked = 0, cyc = 0, n, nc;
    txsw_writeback #(.JAB_CYCLES(200)) txsw_writeback_i (.*);
    txsw_desc_mem txsw_desc_mem_i (.*);
    always #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            close_out;
        end
    end
    task chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            fail_count++;
            $display("Error at %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    task close_out;
        if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    function logic [31:0] ew(input logic [31:0] e);
        ew = e | {16'h0000, |(e & 32'h00004F02), 15'h0000};
    endfunction
    task wt(input int k);
        int t;
        for (t = 0; t < 500; t++) begin
            @(posedge ref_clk);
            if ((k == 0 && tx_go) || (k == 1 && tx_abort) || (k == 2 && cnt != c0)) break;
        end
        if (t == 500) fail_count++;
    endtask
    // waits as long as the slave asks; only the global timeout ends a hang
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge ref_clk);
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= d;
        do @(posedge ref_clk); while (avs_waitrequest);
        r = avs_readdata;
        avs_read <= 1'h0;
        avs_write <= 1'h0;
    endtask
    task send;
        int i;
        c0 = cnt;
        repeat (8) @(posedge ref_clk);
        if (f[6]) begin
            crs_pin <= 1'h1;
            repeat (6) @(posedge ref_clk);
        end
        frame_ready <= 1'h1;
        desc_own <= 1'h1;
        if (f[6]) begin
            repeat (10) @(posedge ref_clk);
            crs_pin <= 1'h0;
        end
        for (i = 0; i <= nc; i++) begin
            wt(0);
            frame_ready <= 1'h0;
            desc_own <= 1'h0;
            crs_pin <= !f[3];
            tx_busy <= 1'h1;
            tx_bytes <= 11'($urandom % 60 + 1);
            repeat (4) @(posedge ref_clk);
            if (i < nc || f[0]) begin
                if (f[0]) tx_bytes <= `TXSW_WINDOW_BYTES + 11'($urandom % 200);
                @(posedge ref_clk);
                col_pin <= 1'h1;
                wt(1);
                col_pin <= 1'h0;
            end else begin
                tx_fifo_empty <= f[1];
                if (f[1] || f[2]) wt(1);
                else begin
                    if (f[4]) crs_pin <= 1'h0;
                    repeat (8) @(posedge ref_clk);
                    tx_sent <= 1'h1;
                    @(posedge ref_clk);
                    tx_sent <= 1'h0;
                    if (f[5]) begin
                        repeat (8) @(posedge ref_clk);
                        col_pin <= 1'h1;
                        repeat (3) @(posedge ref_clk);
                        col_pin <= 1'h0;
                    end
                end
            end
            tx_busy <= 1'h0;
            crs_pin <= 1'h0;
            tx_fifo_empty <= 1'h0;
            if (f[0] || i == 15) break;
        end
        wt(2);
    endtask
    task sc(input int k, input logic [6:0] fl, input logic [31:0] md, input logic [31:0] e,
            input logic [31:0] m);
        nc = k;
        f = fl;
        bus(1'h1, `TXSW_A_MODE, md, q);
        send;
        chk(got & m, ew(e) & m);
        bus(1'h0, `TXSW_A_LAST, 32'h0, q);
        chk(q, got);
    endtask
    task halt(input logic [31:0] s);
        chk(32'(irq), 32'h1);
        chk(32'(tx_stopped | tx_suspended), 32'h1);
        bus(1'h0, `TXSW_A_STAT, 32'h0, q);
        chk(q, s);
        bus(1'h1, `TXSW_A_STAT, s, q);
        bus(1'h0, `TXSW_A_STAT, 32'h0, q);
        chk(q, 32'h0);
        chk(32'(irq), 32'h0);
        bus(1'h1, `TXSW_A_MODE, 32'h1, q);
        repeat (3) @(posedge ref_clk);
        chk(32'(tx_stopped | tx_suspended), 32'h0);
    endtask
    initial begin
        {avs_read, avs_write, crs_pin, col_pin, frame_ready, desc_own} = 6'h00;
        {tx_busy, tx_fifo_empty, tx_sent, link_fail_in} = 4'h0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        tx_bytes = 11'h000;
        q = $urandom(32'hD2B6);
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'h1;
        repeat (4) @(posedge ref_clk);
        bus(1'h0, `TXSW_A_MODE, 32'h0, q);
        chk(q, 32'h0);
        bus(1'h0, `TXSW_A_STAT, 32'h0, q);
        chk(q, 32'h0);
        bus(1'h1, 4'h5 + 4'($urandom % 3), $urandom, q);
        bus(1'h0, 4'h5 + 4'($urandom % 3), 32'h0, q);
        chk(q, 32'h0);
        bus(1'h1, `TXSW_A_MASK, `TXSW_IRQ_MASK, q);
        bus(1'h0, `TXSW_A_MASK, 32'h0, q);
        chk(q, `TXSW_IRQ_MASK);
        n = $urandom % 4 + 1;
        sc(0, 7'h00, 32'h0, 32'h0, M);
        sc(n, 7'h00, 32'h0, 32'(n << 3), 32'hFFFFFFFE);
        sc(0, 7'h00, 32'h0, 32'h0, M);
        sc(16, 7'h00, 32'h0, 32'h100, 32'hFFFFFF86);
        sc(0, 7'h01, 32'h0, 32'h200, M);
        sc(0, 7'h10, 32'h0, 32'h800, M);
        sc(0, 7'h08, 32'h0, 32'h400, 32'hFFFFF7FF);
        sc(0, 7'h08, 32'h400, 32'h0, M);
        sc(0, 7'h40, 32'h0, 32'h1, M);
        sc(0, 7'h20, 32'h01000000, 32'h0, M);
        sc(0, 7'h00, 32'h01000000, 32'h80, M);
        sc(n, 7'h00, 32'h01000000, 32'(n << 3), 32'hFFFFFFFE);
        lk = 1'($urandom);
        link_fail_in <= lk;
        sc(0, 7'h20, 32'h01800000, {29'h0, lk, 2'h0}, M);
        link_fail_in <= 1'h0;
        sc(0, 7'h02, 32'h0, 32'h2, M);
        halt(32'h21);
        sc(0, 7'h04, 32'h0, 32'h4000, 32'hFFFFFF7F);
        halt(32'h08);
        bus(1'h0, `TXSW_A_COUNT, 32'h0, q);
        chk(q, 32'h0000000F);
        // fourteenth frame (underflow) sits in history slot 5
        bus(1'h0, 4'hD, 32'h0, q);
        chk(q, ew(32'h00000002));
        close_out;
    end
endmodule
`default_nettype wire
